//--- include/flash_erase_pkg.sv
// Constants shared by the erase and power control block of the serial flash.
// Assumes a single 250 MHz system clock sampling all serial pins.
package flash_erase_pkg;

    // System clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Opcodes, most significant bit first on the serial input.
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_PAGE_ERASE   = 8'hDB;
    localparam logic [7:0] OP_BLOCK_ERASE  = 8'hD8;
    localparam logic [7:0] OP_DEEP_SLEEP   = 8'hB9;
    localparam logic [7:0] OP_WAKE         = 8'hAB;

    // Frame lengths in serial clock rising edges.
    localparam int unsigned BITS_OPCODE  = 8;
    localparam int unsigned BITS_ADDRESS = 32;

    // Address layout: bits 23..18 are ignored.
    localparam int unsigned ADDR_USED_MSB = 17;
    localparam int unsigned PAGE_LSB      = 8;
    localparam int unsigned SECTOR_LSB    = 16;
    localparam int unsigned PAGE_W        = ADDR_USED_MSB - PAGE_LSB + 1;
    localparam int unsigned SECTOR_W      = ADDR_USED_MSB - SECTOR_LSB + 1;

    // Hardware protected region: the bottom sector.
    localparam logic [SECTOR_W-1:0] PROT_SECTOR = 2'h0;

    // Erased byte value.
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Timing figures in their printed units.
    localparam int unsigned PAGE_ERASE_TIME_US      = 10000;
    localparam int unsigned BLOCK_ERASE_TIME_US     = 2000000;
    localparam int unsigned SLEEP_ENTRY_DELAY_US    = 3;
    localparam int unsigned WAKE_RECOVERY_DELAY_US  = 30;
    localparam int unsigned WRITE_LOCKOUT_DELAY_MS  = 1;

    // Least times round up to whole clock cycles.
    function automatic longint unsigned ps_to_cyc(input longint unsigned ps);
        return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction
    localparam longint unsigned PAGE_ERASE_CYC    = ps_to_cyc(64'(PAGE_ERASE_TIME_US) * 1000000);
    localparam longint unsigned BLOCK_ERASE_CYC   = ps_to_cyc(64'(BLOCK_ERASE_TIME_US) * 1000000);
    localparam longint unsigned SLEEP_ENTRY_CYC   = ps_to_cyc(64'(SLEEP_ENTRY_DELAY_US) * 1000000);
    localparam longint unsigned WAKE_RECOVERY_CYC = ps_to_cyc(64'(WAKE_RECOVERY_DELAY_US) * 1000000);
    localparam longint unsigned WRITE_LOCKOUT_CYC = ps_to_cyc(64'(WRITE_LOCKOUT_DELAY_MS) * 1000000000);

    // Width of the shared timer.
    localparam int unsigned TIMER_W = 32;

    // Power and cycle states.
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ERASING,
        ST_SLEEP_ENTRY,
        ST_SLEEP,
        ST_WAKING
    } power_state_type;

    // Erase kinds.
    typedef enum logic [1:0] {
        ER_NONE,
        ER_PAGE,
        ER_BLOCK
    } erase_kind_type;

endpackage

//--- include/frame_if.sv
// Carries one decoded serial frame from the receiver to the sequencer.
// Both ends run on sys_clk.
interface frame_if;

    logic        done;
    logic [7:0]  opcode;
    logic [23:0] address;
    logic [5:0]  bit_count;
    logic        overrun;

    modport rx
    (
        output done,
        output opcode,
        output address,
        output bit_count,
        output overrun
    );

    modport seq
    (
        input done,
        input opcode,
        input address,
        input bit_count,
        input overrun
    );

endinterface

//--- rtl/serial_frame_rx.sv
// Shifts opcode and address bits in from the serial pins.
// Assumes chip select, serial clock and data are already synchronised.
module serial_frame_rx
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rstn,
    // Synchronised pins
    input  wire logic sel_n,
    input  wire logic sclk,
    input  wire logic sdi,
    // Frame out
    frame_if.rx       frame
);

    logic        sclk_prev_q;
    logic        sclk_prev_d;
    logic        sel_prev_q;
    logic        sel_prev_d;
    logic [31:0] shift_q;
    logic [31:0] shift_d;
    logic [5:0]  count_q;
    logic [5:0]  count_d;
    logic        over_q;
    logic        over_d;
    logic        done_q;
    logic        done_d;

    always_comb
    begin
        sclk_prev_d = sclk;
        sel_prev_d  = sel_n;
        shift_d     = shift_q;
        count_d     = count_q;
        over_d      = over_q;
        done_d      = 1'b0;
        if (sel_n)
        begin
            count_d = 6'h00;
            over_d  = 1'b0;
            // A frame ends on the chip select rising edge.
            if (!sel_prev_q)
            begin
                done_d = 1'b1;
            end
        end
        else if (sclk && !sclk_prev_q)
        begin
            shift_d = {shift_q[30:0], sdi};
            if (count_q == 6'h3F)
            begin
                over_d = 1'b1;
            end
            else
            begin
                count_d = count_q + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sclk_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
            shift_q     <= 32'h0000_0000;
            count_q     <= 6'h00;
            over_q      <= 1'b0;
            done_q      <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_prev_d;
            sel_prev_q  <= sel_prev_d;
            shift_q     <= shift_d;
            count_q     <= count_d;
            over_q      <= over_d;
            done_q      <= done_d;
        end
    end

    // Counter is already zeroed when done pulses, so a held copy is exported.
    logic [5:0] last_count_q;
    logic [5:0] last_count_d;
    logic       last_over_q;
    logic       last_over_d;

    always_comb
    begin
        last_count_d = last_count_q;
        last_over_d  = last_over_q;
        if (!sel_n)
        begin
            last_count_d = count_d;
            last_over_d  = over_d;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            last_count_q <= 6'h00;
            last_over_q  <= 1'b0;
        end
        else
        begin
            last_count_q <= last_count_d;
            last_over_q  <= last_over_d;
        end
    end

    assign frame.done      = done_q;
    assign frame.bit_count = last_count_q;
    assign frame.overrun   = last_over_q;
    // Opcode sits in the low byte only for an 8 bit frame; every other bit count takes the top byte.
    assign frame.opcode    = (last_count_q == 6'd8) ? shift_q[7:0] : shift_q[31:24];
    assign frame.address   = shift_q[23:0];

endmodule

//--- rtl/erase_timer.sv
// Loadable down counter that times the self-timed cycles and delays.
// Assumes a load pulse and value from the sequencer on the same clock.
module erase_timer
#(
    parameter int unsigned WIDTH = 32
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    // Status
    output logic                  expired
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic             exp_q;
    logic             exp_d;

    always_comb
    begin
        count_d = count_q;
        exp_d   = 1'b0;
        if (load)
        begin
            count_d = value;
        end
        else if (count_q != '0)
        begin
            count_d = count_q - 1'b1;
            exp_d   = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            count_q <= '0;
            exp_q   <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            exp_q   <= exp_d;
        end
    end

    assign expired = exp_q;

endmodule

//--- rtl/flash_erase_ctrl.sv
// Erase and power control sequencer of a serial flash memory.
// Assumes the serial pins are asynchronous to sys_clk and the array is outside.
module flash_erase_ctrl
#(
    parameter longint unsigned PAGE_ERASE_CYCLES  = flash_erase_pkg::PAGE_ERASE_CYC,
    parameter longint unsigned BLOCK_ERASE_CYCLES = flash_erase_pkg::BLOCK_ERASE_CYC,
    parameter longint unsigned LOCKOUT_CYCLES     = flash_erase_pkg::WRITE_LOCKOUT_CYC,
    parameter longint unsigned WAKE_CYCLES        = flash_erase_pkg::WAKE_RECOVERY_CYC
)
(
    // Clock and power-on reset
    input  wire logic                                sys_clk,
    input  wire logic                                rstn,
    // Serial pins
    input  wire logic                                sel_n_pin,
    input  wire logic                                sclk_pin,
    input  wire logic                                sdi_pin,
    // Cycles started by other instructions
    input  wire logic                                ext_cycle_busy,
    // Status
    output logic                                     busy_flag,
    output logic                                     write_enable_latch_flag,
    output logic                                     deep_sleep,
    output logic                                     write_locked,
    // Array erase request
    output logic                                     erase_req,
    output logic                                     erase_block,
    output logic [flash_erase_pkg::PAGE_W-1:0]       erase_page,
    output logic [7:0]                               erase_fill
);

    // Two flip-flop synchronisers for the three pins.
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end
        else
        begin
            sync1_q <= {sdi_pin, sclk_pin, sel_n_pin};
            sync2_q <= sync1_q;
        end
    end

    frame_if frame ();

    serial_frame_rx u_rx
    (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .sel_n   (sync2_q[0]),
        .sclk    (sync2_q[1]),
        .sdi     (sync2_q[2]),
        .frame   (frame)
    );

    logic                                    timer_load;
    logic [flash_erase_pkg::TIMER_W-1:0]     timer_value;
    logic                                    timer_expired;

    erase_timer
    #(
        .WIDTH (flash_erase_pkg::TIMER_W)
    )
    u_timer
    (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (timer_load),
        .value   (timer_value),
        .expired (timer_expired)
    );

    flash_erase_pkg::power_state_type        state_q;
    flash_erase_pkg::power_state_type        state_d;
    logic                                    wel_q;
    logic                                    wel_d;
    logic [flash_erase_pkg::TIMER_W-1:0]     lock_q;
    logic [flash_erase_pkg::TIMER_W-1:0]     lock_d;
    logic                                    req_q;
    logic                                    req_d;
    logic                                    blk_q;
    logic                                    blk_d;
    logic [flash_erase_pkg::PAGE_W-1:0]      page_q;
    logic [flash_erase_pkg::PAGE_W-1:0]      page_d;

    // Decode of the completed frame.
    logic                                    full_addr;
    logic                                    only_op;
    logic                                    is_pe;
    logic                                    is_be;
    logic                                    is_write_enable_cmd;
    logic                                    is_sleep;
    logic                                    is_wake;
    logic                                    protected_hit;
    logic                                    cycle_running;
    logic                                    locked;
    logic [flash_erase_pkg::PAGE_W-1:0]      addr_page;
    logic [flash_erase_pkg::SECTOR_W-1:0]    addr_sector;

    always_comb
    begin
        full_addr = (frame.bit_count == 6'(flash_erase_pkg::BITS_ADDRESS)) && !frame.overrun;
        only_op   = (frame.bit_count == 6'(flash_erase_pkg::BITS_OPCODE)) && !frame.overrun;
        is_pe     = full_addr && (frame.opcode == flash_erase_pkg::OP_PAGE_ERASE);
        is_be     = full_addr && (frame.opcode == flash_erase_pkg::OP_BLOCK_ERASE);
        is_write_enable_cmd   = only_op && (frame.opcode == flash_erase_pkg::OP_WRITE_ENABLE);
        is_sleep  = only_op && (frame.opcode == flash_erase_pkg::OP_DEEP_SLEEP);
        is_wake   = only_op && (frame.opcode == flash_erase_pkg::OP_WAKE);
        addr_page   = frame.address[flash_erase_pkg::ADDR_USED_MSB:flash_erase_pkg::PAGE_LSB];
        addr_sector = frame.address[flash_erase_pkg::ADDR_USED_MSB:flash_erase_pkg::SECTOR_LSB];
        protected_hit = (addr_sector == flash_erase_pkg::PROT_SECTOR);
        cycle_running = (state_q == flash_erase_pkg::ST_ERASING) || ext_cycle_busy;
        locked        = (lock_q != '0);
    end

    always_comb
    begin
        state_d     = state_q;
        wel_d       = wel_q;
        lock_d      = locked ? lock_q - 1'b1 : lock_q;
        req_d       = 1'b0;
        blk_d       = blk_q;
        page_d      = page_q;
        timer_load  = 1'b0;
        timer_value = '0;
        case (state_q)
            flash_erase_pkg::ST_STANDBY:
            begin
                if (frame.done && !cycle_running)
                begin
                    if (is_write_enable_cmd && !locked)
                    begin
                        wel_d = 1'b1;
                    end
                    else if ((is_pe || is_be) && wel_q && !locked && !protected_hit)
                    begin
                        state_d     = flash_erase_pkg::ST_ERASING;
                        blk_d       = is_be;
                        page_d      = addr_page;
                        timer_load  = 1'b1;
                        timer_value = is_be ? flash_erase_pkg::TIMER_W'(BLOCK_ERASE_CYCLES)
                                            : flash_erase_pkg::TIMER_W'(PAGE_ERASE_CYCLES);
                    end
                    else if (is_sleep)
                    begin
                        state_d     = flash_erase_pkg::ST_SLEEP_ENTRY;
                        timer_load  = 1'b1;
                        timer_value = flash_erase_pkg::TIMER_W'(flash_erase_pkg::SLEEP_ENTRY_CYC);
                    end
                end
            end
            flash_erase_pkg::ST_ERASING:
            begin
                if (timer_expired)
                begin
                    req_d   = 1'b1;
                    wel_d   = 1'b0;
                    state_d = flash_erase_pkg::ST_STANDBY;
                end
            end
            flash_erase_pkg::ST_SLEEP_ENTRY:
            begin
                if (timer_expired)
                begin
                    state_d = flash_erase_pkg::ST_SLEEP;
                end
            end
            flash_erase_pkg::ST_SLEEP:
            begin
                if (frame.done && is_wake)
                begin
                    state_d     = flash_erase_pkg::ST_WAKING;
                    timer_load  = 1'b1;
                    timer_value = flash_erase_pkg::TIMER_W'(WAKE_CYCLES);
                end
            end
            flash_erase_pkg::ST_WAKING:
            begin
                if (timer_expired)
                begin
                    state_d = flash_erase_pkg::ST_STANDBY;
                end
            end
            default:
            begin
                state_d = flash_erase_pkg::ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_q <= flash_erase_pkg::ST_STANDBY;
            wel_q   <= 1'b0;
            lock_q  <= flash_erase_pkg::TIMER_W'(LOCKOUT_CYCLES);
            req_q   <= 1'b0;
            blk_q   <= 1'b0;
            page_q  <= '0;
        end
        else
        begin
            state_q <= state_d;
            wel_q   <= wel_d;
            lock_q  <= lock_d;
            req_q   <= req_d;
            blk_q   <= blk_d;
            page_q  <= page_d;
        end
    end

    // The array is rewritten only as the cycle closes, so an aborted
    // power-down leaves the old contents rather than a half-erased range.
    assign busy_flag               = (state_q == flash_erase_pkg::ST_ERASING);
    assign write_enable_latch_flag = wel_q;
    assign deep_sleep              = (state_q == flash_erase_pkg::ST_SLEEP);
    assign write_locked            = locked;
    assign erase_req               = req_q;
    assign erase_block             = blk_q;
    assign erase_page              = page_q;
    assign erase_fill              = flash_erase_pkg::ERASED_BYTE;

endmodule

//--- tb/flash_erase_ctrl_properties.sv
// Concurrent checks on the erase and power control block.
// Assumes a bind to flash_erase_ctrl; it sees that module's ports only.
module flash_erase_ctrl_properties
#(
    parameter longint unsigned PAGE_ERASE_CYCLES  = 50,
    parameter longint unsigned BLOCK_ERASE_CYCLES = 100,
    parameter longint unsigned LOCKOUT_CYCLES     = 20,
    parameter longint unsigned WAKE_CYCLES        = 30
)
(
    // Clock and reset
    input wire logic                                sys_clk,
    input wire logic                                rstn,
    // Pins
    input wire logic                                sel_n_pin,
    input wire logic                                sclk_pin,
    input wire logic                                sdi_pin,
    input wire logic                                ext_cycle_busy,
    // Status and erase request
    input wire logic                                busy_flag,
    input wire logic                                write_enable_latch_flag,
    input wire logic                                deep_sleep,
    input wire logic                                write_locked,
    input wire logic                                erase_req,
    input wire logic                                erase_block,
    input wire logic [flash_erase_pkg::PAGE_W-1:0]  erase_page,
    input wire logic [7:0]                          erase_fill
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Counts how long busy has stood, so an erase that ends early shows up.
    logic [31:0] busy_len_q;
    logic [31:0] busy_len_d;
    always_comb busy_len_d = (rstn && busy_flag) ? busy_len_q + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk) busy_len_q <= busy_len_d;

    property p_power_up; $rose(rstn) |-> !busy_flag && !write_enable_latch_flag && !deep_sleep;
    endproperty
    property p_lock_hold; $rose(rstn) |-> write_locked [*8]; endproperty
    property p_lock_latch; write_locked |-> !write_enable_latch_flag; endproperty
    property p_fill; erase_req |-> erase_fill == flash_erase_pkg::ERASED_BYTE; endproperty
    property p_req_end; erase_req |-> ##[0:1] (!busy_flag && !write_enable_latch_flag);
    endproperty
    property p_req_len; erase_req |-> $past(busy_flag)
        && busy_len_q >= (erase_block ? BLOCK_ERASE_CYCLES : PAGE_ERASE_CYCLES) - 1;
    endproperty
    property p_req_pulse; erase_req |=> !erase_req; endproperty
    property p_protect; erase_req |->
        erase_page[flash_erase_pkg::PAGE_W-1 -: 2] != flash_erase_pkg::PROT_SECTOR;
    endproperty
    property p_busy_awake; busy_flag |-> !deep_sleep; endproperty
    property p_busy_start; $rose(busy_flag) |-> write_enable_latch_flag && !write_locked;
    endproperty
    property p_latch_rise; $rose(write_enable_latch_flag) |-> !busy_flag && !deep_sleep;
    endproperty

    a_power_up: assert property (p_power_up) else $error("bad state after reset");
    a_lock_hold: assert property (p_lock_hold) else $error("lockout too short");
    a_lock_latch: assert property (p_lock_latch) else $error("latch set in lockout");
    a_fill: assert property (p_fill) else $error("erase fill not all ones");
    a_req_end: assert property (p_req_end) else $error("busy or latch left set");
    a_req_len: assert property (p_req_len) else $error("erase cycle too short");
    a_req_pulse: assert property (p_req_pulse) else $error("erase request too long");
    a_protect: assert property (p_protect) else $error("protected sector erased");
    a_busy_awake: assert property (p_busy_awake) else $error("asleep while busy");
    a_busy_start: assert property (p_busy_start) else $error("erase without latch");
    a_latch_rise: assert property (p_latch_rise) else $error("latch set while busy");

    c_page: cover property (erase_req && !erase_block);
    c_block: cover property (erase_req && erase_block);
    c_sleep: cover property ($rose(deep_sleep));
endmodule

//--- tb/spi_host_model.sv
// Behavioural host that frames commands on the serial pins.
// Assumes sys_clk only paces the edges; the serial clock idles low.
module spi_host_model
(
    // Pacing clock
    input wire logic sys_clk,
    // Serial pins
    output logic     sel_n,
    output logic     sclk,
    output logic     sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Sends the low n bits of bits; the serial clock period is 32 ns.
    task automatic send(input logic [39:0] bits, input int n);
        // select low over the whole frame.
        sel_n = 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            // data settles before the rising edge, top bit first.
            sdi = bits[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        tick(4);
        // select rises four cycles after the last bit's falling edge.
        sel_n = 1'b1;
        // A released data line shows the inverse level, so a stale bit is never trusted.
        sdi = ~sdi;
        tick(4);
    endtask
endmodule

//--- tb/serial_flash_erase_power_control_tb.sv
// Self-checking bench for the erase and power control block.
// Assumes the host model drives the pins and the checker is bound below.
module serial_flash_erase_power_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PAGE_CYC = 400;
    localparam int BLOCK_CYC = 800;
    localparam int LOCK_CYC = 300;
    localparam int WAKE_CYC = 30;
    localparam logic [7:0] C_WE = flash_erase_pkg::OP_WRITE_ENABLE;
    localparam logic [7:0] C_PG = flash_erase_pkg::OP_PAGE_ERASE;
    localparam logic [7:0] C_BK = flash_erase_pkg::OP_BLOCK_ERASE;
    localparam logic [7:0] C_SL = flash_erase_pkg::OP_DEEP_SLEEP;
    localparam logic [7:0] C_WK = flash_erase_pkg::OP_WAKE;

    logic                               sys_clk;
    logic                               rstn;
    logic                               sel_n;
    logic                               sclk;
    logic                               sdi;
    logic                               ext_cycle_busy;
    logic                               busy_flag;
    logic                               write_enable_latch_flag;
    logic                               deep_sleep;
    logic                               write_locked;
    logic                               erase_req;
    logic                               erase_block;
    logic [flash_erase_pkg::PAGE_W-1:0] erase_page;
    logic [7:0]                         erase_fill;
    int                                 fail_count;
    int                                 n_checks;
    bit                                 m_wel;
    bit                                 m_sleep;
    bit                                 m_busy;
    bit                                 m_locked;
    logic [10:0]                        exp_q[$];

    spi_host_model u_spi_host_model (.sys_clk, .sel_n, .sclk, .sdi);

    flash_erase_ctrl #(.PAGE_ERASE_CYCLES(PAGE_CYC), .BLOCK_ERASE_CYCLES(BLOCK_CYC),
        .LOCKOUT_CYCLES(LOCK_CYC), .WAKE_CYCLES(WAKE_CYC)) u_flash_erase_ctrl (
        .sys_clk, .rstn, .sel_n_pin(sel_n), .sclk_pin(sclk), .sdi_pin(sdi), .ext_cycle_busy,
        .busy_flag, .write_enable_latch_flag, .deep_sleep, .write_locked, .erase_req,
        .erase_block, .erase_page, .erase_fill);

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_idle;
        int i;
        for (i = 0; i < 1000 && busy_flag !== 1'b0; i++) tick(1);
        check("idle", 16'(busy_flag), 16'h0);
        if (i == 1000) print_verdict();
    endtask

    // Sends one frame and moves the reference model the way the device should.
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
        bit idle;
        bit er;
        idle = !m_sleep && !m_busy && ext_cycle_busy !== 1'b1;
        er = op == C_PG || op == C_BK;
        u_spi_host_model.send(40'({op, a}) >> (32 - n), n);
        if (idle && n == 8 && op == C_WE && !m_locked)
            m_wel = 1'b1;
        if (idle && er && n == 32 && m_wel && a[17:16] != flash_erase_pkg::PROT_SECTOR)
        begin
            m_busy = 1'b1;
            exp_q.push_back({op == C_BK, a[17:8]});
        end
        if (idle && n == 8 && op == C_SL)
            m_sleep = 1'b1;
        else if (m_sleep && n == 8 && op == C_WK)
            m_sleep = 1'b0;
        tick(12);
        check("latch", 16'(write_enable_latch_flag), 16'(m_wel));
        check("busy", 16'(busy_flag), 16'(m_busy));
        if (op != C_SL)
            check("sleep", 16'(deep_sleep), 16'(m_sleep));
    endtask

    always @(posedge sys_clk)
    begin
        if (rstn === 1'b1 && erase_req === 1'b1)
        begin
            check("erase_expected", 16'(exp_q.size() > 0), 16'h1);
            if (exp_q.size() > 0)
            begin
                check("kind", 16'(erase_block), 16'(exp_q[0][10]));
                check("page", 16'(erase_page) >> (exp_q[0][10] * 8),
                    16'(exp_q[0][9:0]) >> (exp_q[0][10] * 8));
                check("fill", 16'(erase_fill), 16'h00FF);
                void'(exp_q.pop_front());
            end
        end
    end

    initial
    begin
        logic [23:0] a;
        int i;
        void'($urandom(1197));
        {rstn, ext_cycle_busy, m_wel, m_sleep, m_busy, m_locked} = 6'h01;
        fail_count = 0;
        n_checks = 0;
        repeat (10) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        tick(4);
        check("locked", 16'(write_locked), 16'h1);
        cmd(C_WE, 24'h0, 8);
        tick(LOCK_CYC);
        m_locked = 1'b0;
        check("locked", 16'(write_locked), 16'h0);
        for (int k = 0; k < 2; k++)
        begin
            a = 24'($urandom);
            a[17:16] = 2'($urandom_range(3, 1));
            cmd(k ? C_BK : C_PG, a, 32);
            cmd(C_WE, 24'h0, 8);
            cmd(k ? C_BK : C_PG, a, 31);
            cmd(k ? C_BK : C_PG, a, 32);
            cmd(k ? C_PG : C_SL, a, k ? 32 : 8);
            wait_idle();
            m_busy = 1'b0;
            m_wel = 1'b0;
            check("latch_end", 16'(write_enable_latch_flag), 16'h0);
        end
        cmd(C_SL, 24'h0, 8);
        check("sleep_early", 16'(deep_sleep), 16'h0);
        for (i = 0; i < 1000 && deep_sleep !== 1'b1; i++) tick(1);
        check("sleep_late", 16'(i > 600), 16'h1);
        check("sleep_on", 16'(deep_sleep), 16'h1);
        if (deep_sleep !== 1'b1) print_verdict();
        cmd(C_WE, 24'h0, 8);
        cmd(C_WK, 24'h0, 9);
        cmd(C_WK, 24'h0, 8);
        // host stays deselected through the recovery delay.
        tick(WAKE_CYC);
        cmd(C_WE, 24'h0, 8);
        ext_cycle_busy = 1'b1;
        cmd(C_BK, a, 32);
        ext_cycle_busy = 1'b0;
        a[17:16] = flash_erase_pkg::PROT_SECTOR;
        cmd(C_PG, a, 32);
        check("pending", 16'(exp_q.size()), 16'h0);
        print_verdict();
    end
endmodule

bind flash_erase_ctrl flash_erase_ctrl_properties #(.PAGE_ERASE_CYCLES, .BLOCK_ERASE_CYCLES,
    .LOCKOUT_CYCLES, .WAKE_CYCLES) u_flash_erase_ctrl_properties (
    .sys_clk, .rstn, .sel_n_pin, .sclk_pin, .sdi_pin, .ext_cycle_busy, .busy_flag,
    .write_enable_latch_flag, .deep_sleep, .write_locked, .erase_req, .erase_block,
    .erase_page, .erase_fill);
